//--- core_model.sv
`timescale 1ns/10ps
module core_model
(
  // clock
  input  wire logic       sys_clk,
  // bench commands
  input  wire logic [3:0] pend_cmd,
  input  wire logic [6:0] act_cmd,
  // block side
  input  wire logic       system_reset_request,
  output logic      [3:0] pend_set,
  output logic      [6:0] act_set,
  output logic            warm_rst_n
);
  initial warm_rst_n = 1'b1;
  initial pend_set = 4'h0;
  initial act_set = 7'h00;
  // events are one-cycle pulses launched just after the edge
  always @(posedge sys_clk)
  begin
    pend_set   <= pend_cmd;
    act_set    <= act_cmd;
    // the request becomes a warm reset; stack rebuild stays with software
    warm_rst_n <= !system_reset_request;
  end
endmodule : core_model

//--- preempt_group.sv
`timescale 1ns/10ps

// keeps the pre-emption part of one stored priority for the given grouping
module preempt_group
(
  // priority in
  input  wire logic [2:0] pri,
  input  wire logic [2:0] grouping,
  // pre-emption part out
  output logic      [2:0] preempt
);

  genvar b;
  generate
    for (b = 0; b < 3; b = b + 1)
    begin : g_bit
      // byte bit (5 + b) belongs to pre-emption when above the grouping point
      assign preempt[b] = pri[b] & ((sys_exc_pkg::PRI_LSB_IN_BYTE + b) > int'(grouping));
    end
  endgenerate

endmodule : preempt_group

//--- sys_exc_chk_sva.sv
`timescale 1ns/10ps
module sys_exc_chk
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // register port
  input  wire logic [31:0] addr,
  input  wire logic [31:0] wr_data,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  input  wire logic [31:0] rd_data,
  // core events
  input  wire logic [3:0]  pend_set,
  input  wire logic [6:0]  act_set,
  // control outputs
  input  wire logic        system_reset_request,
  input  wire logic        core_reset_pulse,
  input  wire logic        clear_active_pulse,
  input  wire logic [2:0]  priority_grouping,
  input  wire logic [2:0]  fault_enable,
  input  wire logic [3:0]  pending_flags,
  input  wire logic [6:0]  active_flags
);
  wire rc_wr  = wr_en && addr == sys_exc_pkg::ADDR_RESET_CTRL;
  wire key_ok = wr_data[31:16] == sys_exc_pkg::RESET_KEY_WRITE;
  wire key_wr = rc_wr && key_ok;
  wire pri_rd = rd_en && (addr == sys_exc_pkg::ADDR_PRI_WORD_A
    || addr == sys_exc_pkg::ADDR_PRI_WORD_B || addr == sys_exc_pkg::ADDR_PRI_WORD_C);

  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  AST_SRR_RISE:
    assert property ($rose(system_reset_request) |-> $past(key_wr && wr_data[2]))
    else $error("reset request rose without keyed write");
  AST_SRR_HOLD:
    assert property (system_reset_request |=> system_reset_request)
    else $error("reset request dropped without warm reset");
  AST_CLR_PULSE:
    assert property (key_wr && wr_data[1] |=> clear_active_pulse ##1 !clear_active_pulse)
    else $error("clear active pulse wrong");
  AST_CLR_ACT:
    assert property (key_wr && wr_data[1] && act_set == 7'h00 |=> active_flags == 7'h00)
    else $error("active flags not erased");
  AST_CORE_PULSE:
    assert property (key_wr && wr_data[0] |=> core_reset_pulse ##1 !core_reset_pulse)
    else $error("core reset pulse wrong");
  AST_KEY_REFUSE:
    assert property (rc_wr && !key_ok |=> !core_reset_pulse && !clear_active_pulse
      && $stable(priority_grouping) && $stable(system_reset_request))
    else $error("unkeyed write took effect");
  AST_GROUPING:
    assert property (key_wr |=> priority_grouping == $past(wr_data[10:8]))
    else $error("grouping not taken");
  AST_RC_READ:
    assert property (rd_en && addr == sys_exc_pkg::ADDR_RESET_CTRL
      |=> rd_data[31:16] == 16'hFA05 && rd_data[1:0] == 2'b00)
    else $error("reset control read wrong");
  AST_PRI_UNUSED:
    assert property (pri_rd |=> (rd_data & 32'h1F1F_1F1F) == 32'h0000_0000)
    else $error("unused priority bits not zero");
  AST_ENABLE:
    assert property (wr_en && addr == sys_exc_pkg::ADDR_HANDLER_CTRL
      |=> fault_enable == $past(wr_data[18:16]))
    else $error("fault enables not taken");
  AST_PEND:
    assert property (pend_set != 4'h0 |=> (pending_flags & $past(pend_set)) == $past(pend_set))
    else $error("pending flag not set");
endmodule : sys_exc_chk

//--- sys_exc_pkg.sv
package sys_exc_pkg;

  // register byte addresses
  localparam logic [31:0] ADDR_RESET_CTRL    = 32'hE000_ED0C;
  localparam logic [31:0] ADDR_PRI_WORD_A    = 32'hE000_ED18;
  localparam logic [31:0] ADDR_PRI_WORD_B    = 32'hE000_ED1C;
  localparam logic [31:0] ADDR_PRI_WORD_C    = 32'hE000_ED20;
  localparam logic [31:0] ADDR_HANDLER_CTRL  = 32'hE000_ED24;
  localparam logic [31:0] ADDR_EVENT_STATUS  = 32'hE000_ED40;
  localparam logic [31:0] ADDR_EVENT_MASK    = 32'hE000_ED44;

  // reset-control fields
  localparam logic [15:0] RESET_KEY_WRITE    = 16'h05FA;
  localparam logic [15:0] RESET_KEY_READ     = 16'hFA05;
  localparam int          KEY_LSB            = 16;
  localparam int          ENDIAN_BIT         = 15;
  localparam int          GROUPING_LSB       = 8;
  localparam int          SYS_RESET_REQ_BIT  = 2;
  localparam int          CLR_ACTIVE_BIT     = 1;
  localparam int          CORE_RESET_BIT     = 0;
  localparam logic [2:0]  GROUPING_RESET     = 3'h0;
  localparam logic        ENDIAN_RESET       = 1'b0;

  // priority slots 4..15, three stored bits at the top of each byte
  localparam int          SLOT_COUNT         = 12;
  localparam int          SLOT_BASE          = 4;
  localparam int          PRI_LSB_IN_BYTE    = 5;
  localparam logic [11:0] SLOT_IMPLEMENTED   = 12'h0D8F;
  localparam logic [2:0]  PRI_RESET          = 3'h0;

  // handler control fields
  localparam int          ENABLE_LSB         = 16;
  localparam int          PENDING_LSB        = 12;
  localparam logic [2:0]  ENABLE_RESET       = 3'h0;
  localparam logic [3:0]  PENDING_RESET      = 4'h0;
  localparam logic [6:0]  ACTIVE_RESET       = 7'h00;
  // active vector index: 0 mem, 1 bus, 2 usage, 3 svcall, 4 monitor, 5 pendsv, 6 tick
  localparam int          ACT_MEM_BIT        = 0;
  localparam int          ACT_BUS_BIT        = 1;
  localparam int          ACT_USAGE_BIT      = 3;
  localparam int          ACT_SVCALL_BIT     = 7;
  localparam int          ACT_MONITOR_BIT    = 8;
  localparam int          ACT_PENDSV_BIT     = 10;
  localparam int          ACT_TICK_BIT       = 11;

  // event status and mask
  localparam int          EVENT_COUNT        = 8;
  localparam logic [7:0]  EVENT_RESET        = 8'h00;

endpackage : sys_exc_pkg

//--- system_exception_control.sv
`timescale 1ns/10ps

// Notes on behaviour
// - Writing one to the system reset request bit drives the system reset request output.
// - That request brings a warm reset, and the warm reset clears the request bit.
// - Writing one to clear-active-vectors erases all active state except bits the core sets in the same cycle; the bit self-clears.
// - Writing one to the core reset bit resets all but debug logic and reads back zero.
// - Memory format is little endian after reset unless the strap selects otherwise.
// - Each system exception has an eight-bit priority lane, four lanes to a word.
// - Only the top three bits of each lane are stored and used for comparison.
// - Unimplemented priority bits read zero and ignore writes.
// - Word A holds memory fault in 7-5, bus fault in 15-13, usage fault in 23-21.
// - Priority words sit at consecutive word addresses for slots 4-7, 8-11, 12-15.
// - Reset-control writes act only with key 0x5FA in the upper halfword.
// - Grouping splits priorities; only the pre-emption part decides nesting.
module system_exception_control
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // register port
  input  wire logic [31:0] addr,
  input  wire logic [31:0] wr_data,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [31:0] rd_data,
  // core events
  input  wire logic [3:0]  pend_set,
  input  wire logic [3:0]  pend_clr,
  input  wire logic [6:0]  act_set,
  input  wire logic [6:0]  act_clr,
  // strap pin
  input  wire logic        big_endian_strap,
  // control outputs
  output logic             system_reset_request,
  output logic             core_reset_pulse,
  output logic             clear_active_pulse,
  output logic             big_endian,
  output logic      [2:0]  priority_grouping,
  output logic      [2:0]  fault_enable,
  output logic      [3:0]  pending_flags,
  output logic      [6:0]  active_flags,
  output logic             preempt_request,
  output logic      [3:0]  preempt_slot,
  output logic             irq
);

  // register state
  logic        sys_req_r;
  logic        core_rst_r;
  logic        clr_act_r;
  logic        big_endian_r;
  logic        strap_done_r;
  logic        strap_s1_r;
  logic        strap_s2_r;
  logic [2:0]  grouping_r;
  logic [2:0]  enable_r;
  logic [3:0]  pend_r;
  logic [6:0]  act_r;
  logic [7:0]  status_r;
  logic [7:0]  mask_r;
  logic        preempt_r;
  logic [3:0]  preempt_slot_r;
  logic        irq_r;
  logic [31:0] rd_data_r;

  // decode
  wire         sel_reset  = (addr == sys_exc_pkg::ADDR_RESET_CTRL);
  wire         sel_pri_a  = (addr == sys_exc_pkg::ADDR_PRI_WORD_A);
  wire         sel_pri_b  = (addr == sys_exc_pkg::ADDR_PRI_WORD_B);
  wire         sel_pri_c  = (addr == sys_exc_pkg::ADDR_PRI_WORD_C);
  wire         sel_hctl   = (addr == sys_exc_pkg::ADDR_HANDLER_CTRL);
  wire         sel_status = (addr == sys_exc_pkg::ADDR_EVENT_STATUS);
  wire         sel_mask   = (addr == sys_exc_pkg::ADDR_EVENT_MASK);
  wire         key_ok     = (wr_data[31:16] == sys_exc_pkg::RESET_KEY_WRITE);
  wire         reset_wr   = wr_en & sel_reset & key_ok;
  wire         hctl_wr    = wr_en & sel_hctl;
  wire [2:0]   pri_word_wr;

  assign pri_word_wr = {3{wr_en}} & {sel_pri_c, sel_pri_b, sel_pri_a};

  // reset-control requests
  wire         sys_req_set = reset_wr & wr_data[sys_exc_pkg::SYS_RESET_REQ_BIT];
  wire         clr_act_set = reset_wr & wr_data[sys_exc_pkg::CLR_ACTIVE_BIT];
  wire         core_rst_set = reset_wr & wr_data[sys_exc_pkg::CORE_RESET_BIT];

  // priority storage, one lane per slot
  wire  [2:0]  pri_val [sys_exc_pkg::SLOT_COUNT];
  wire  [2:0]  grp_val [sys_exc_pkg::SLOT_COUNT];

  genvar s;
  generate
    for (s = 0; s < sys_exc_pkg::SLOT_COUNT; s = s + 1)
    begin : g_slot
      localparam int WORD = s / 4;
      localparam int LANE = s % 4;
      localparam int LSB  = 8 * LANE + sys_exc_pkg::PRI_LSB_IN_BYTE;
      if (sys_exc_pkg::SLOT_IMPLEMENTED[s])
      begin : g_impl
        logic [2:0] lane_r;
        // only bits 7-5 of the lane are kept; lower bits are dropped
        always_ff @(posedge sys_clk)
        begin
          if (!rst_n)
            lane_r <= sys_exc_pkg::PRI_RESET;
          else if (pri_word_wr[WORD])
            lane_r <= wr_data[LSB +: 3];
        end
        assign pri_val[s] = lane_r;
      end
      else
      begin : g_none
        assign pri_val[s] = 3'h0;
      end
      preempt_group u_grp
      (
        .pri      (pri_val[s]),
        .grouping (grouping_r),
        .preempt  (grp_val[s])
      );
    end
  endgenerate

  // word images: top three bits of each byte, rest zero
  wire  [31:0] pri_word [3];
  genvar w;
  generate
    for (w = 0; w < 3; w = w + 1)
    begin : g_word
      assign pri_word[w] = {pri_val[4*w+3], 5'h00, pri_val[4*w+2], 5'h00,
                            pri_val[4*w+1], 5'h00, pri_val[4*w], 5'h00};
    end
  endgenerate

  // handler control next values; hardware sets win over any clear
  wire  [6:0]  act_wr_img = {wr_data[sys_exc_pkg::ACT_TICK_BIT],
                             wr_data[sys_exc_pkg::ACT_PENDSV_BIT],
                             wr_data[sys_exc_pkg::ACT_MONITOR_BIT],
                             wr_data[sys_exc_pkg::ACT_SVCALL_BIT],
                             wr_data[sys_exc_pkg::ACT_USAGE_BIT],
                             wr_data[sys_exc_pkg::ACT_BUS_BIT],
                             wr_data[sys_exc_pkg::ACT_MEM_BIT]};
  wire  [6:0]  act_base   = hctl_wr ? act_wr_img : act_r;
  wire  [6:0]  act_nxt    = act_set | (act_base & ~act_clr & ~{7{clr_act_set}});
  wire  [3:0]  pend_base  = hctl_wr ? wr_data[sys_exc_pkg::PENDING_LSB +: 4] : pend_r;
  wire  [3:0]  pend_nxt   = pend_set | (pend_base & ~pend_clr);

  wire  [31:0] hctl_img;
  assign hctl_img = {13'h0000, enable_r, pend_r,
                     act_r[6], act_r[5], 1'b0, act_r[4], act_r[3],
                     3'h0, act_r[2], 1'b0, act_r[1], act_r[0]};

  // nesting: pick best pending by full priority, nest by pre-emption only
  logic [11:0] pend_vec;
  logic [11:0] act_vec;
  logic        pend_found;
  logic        act_found;
  logic [2:0]  best_pri;
  logic [3:0]  best_idx;
  logic [2:0]  run_grp;
  logic        preempt_nxt;

  always_comb
  begin
    pend_vec       = 12'h000;
    pend_vec[0]    = pend_r[1] & enable_r[0];
    pend_vec[1]    = pend_r[2] & enable_r[1];
    pend_vec[2]    = pend_r[0] & enable_r[2];
    pend_vec[7]    = pend_r[3];
    act_vec        = 12'h000;
    act_vec[0]     = act_r[0];
    act_vec[1]     = act_r[1];
    act_vec[2]     = act_r[2];
    act_vec[7]     = act_r[3];
    act_vec[8]     = act_r[4];
    act_vec[10]    = act_r[5];
    act_vec[11]    = act_r[6];
    pend_found     = 1'b0;
    act_found      = 1'b0;
    best_pri       = 3'h7;
    best_idx       = 4'h0;
    run_grp        = 3'h7;
    for (int i = 0; i < sys_exc_pkg::SLOT_COUNT; i++)
    begin
      if (pend_vec[i] && (!pend_found || pri_val[i] < best_pri))
      begin
        pend_found = 1'b1;
        best_pri   = pri_val[i];
        best_idx   = 4'(i);
      end
      if (act_vec[i] && (!act_found || grp_val[i] < run_grp))
      begin
        act_found = 1'b1;
        run_grp   = grp_val[i];
      end
    end
    preempt_nxt = pend_found && (!act_found || grp_val[best_idx] < run_grp);
  end

  // events: pending set x4, clear-active, core reset, system reset, nesting rise
  wire  [7:0]  events     = {preempt_nxt & ~preempt_r, sys_req_set, core_rst_set,
                             clr_act_set, pend_set};
  wire  [7:0]  status_w1c = (wr_en & sel_status) ? wr_data[7:0] : 8'h00;
  wire  [7:0]  status_nxt = events | (status_r & ~status_w1c);

  // read mux; core-reset and clear-active bits of reset control read zero, request bit reads back
  wire  [31:0] reset_img  = {sys_exc_pkg::RESET_KEY_READ, big_endian_r, 4'h0, grouping_r,
                             5'h00, sys_req_r, 2'h0};
  wire  [31:0] rd_mux     = sel_reset  ? reset_img :
                            sel_pri_a  ? pri_word[0] :
                            sel_pri_b  ? pri_word[1] :
                            sel_pri_c  ? pri_word[2] :
                            sel_hctl   ? hctl_img :
                            sel_status ? {24'h00_0000, status_r} :
                            sel_mask   ? {24'h00_0000, mask_r} : 32'h0000_0000;

  // strap passes two flops; no reset needed on pure sampling stages
  always_ff @(posedge sys_clk)
  begin
    strap_s1_r <= big_endian_strap;
    strap_s2_r <= strap_s1_r;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      big_endian_r <= sys_exc_pkg::ENDIAN_RESET;
      strap_done_r <= 1'b0;
    end
    else if (!strap_done_r)
    begin
      big_endian_r <= strap_s2_r;
      strap_done_r <= 1'b1;
    end
  end

  // request bit holds until the warm reset it triggers comes back on rst_n
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      sys_req_r <= 1'b0;
    else if (sys_req_set)
      sys_req_r <= 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      core_rst_r <= 1'b0;
      clr_act_r  <= 1'b0;
    end
    else
    begin
      core_rst_r <= core_rst_set;
      clr_act_r  <= clr_act_set;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      grouping_r <= sys_exc_pkg::GROUPING_RESET;
    else if (reset_wr)
      grouping_r <= wr_data[sys_exc_pkg::GROUPING_LSB +: 3];
  end

  // software writes to active bits do not touch stack state
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      enable_r <= sys_exc_pkg::ENABLE_RESET;
      pend_r   <= sys_exc_pkg::PENDING_RESET;
      act_r    <= sys_exc_pkg::ACTIVE_RESET;
    end
    else
    begin
      if (hctl_wr)
        enable_r <= wr_data[sys_exc_pkg::ENABLE_LSB +: 3];
      pend_r <= pend_nxt;
      act_r  <= act_nxt;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      status_r <= sys_exc_pkg::EVENT_RESET;
      mask_r   <= sys_exc_pkg::EVENT_RESET;
      irq_r    <= 1'b0;
    end
    else
    begin
      status_r <= status_nxt;
      if (wr_en && sel_mask)
        mask_r <= wr_data[7:0];
      irq_r <= |(status_nxt & mask_r);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      preempt_r      <= 1'b0;
      preempt_slot_r <= 4'h0;
    end
    else
    begin
      preempt_r      <= preempt_nxt;
      preempt_slot_r <= 4'(best_idx + sys_exc_pkg::SLOT_BASE);
    end
  end

  // read data stand one cycle only
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      rd_data_r <= 32'h0000_0000;
    else
      rd_data_r <= rd_en ? rd_mux : 32'h0000_0000;
  end

  assign rd_data              = rd_data_r;
  assign system_reset_request = sys_req_r;
  assign core_reset_pulse     = core_rst_r;
  assign clear_active_pulse   = clr_act_r;
  assign big_endian           = big_endian_r;
  assign priority_grouping    = grouping_r;
  assign fault_enable         = enable_r;
  assign pending_flags        = pend_r;
  assign active_flags         = act_r;
  assign preempt_request      = preempt_r;
  assign preempt_slot         = preempt_slot_r;
  assign irq                  = irq_r;

endmodule : system_exception_control

//--- system_exception_control_tb.sv
`timescale 1ns/10ps
module system_exception_control_tb;
  localparam logic [31:0] RC  = sys_exc_pkg::ADDR_RESET_CTRL;
  localparam logic [31:0] PA  = sys_exc_pkg::ADDR_PRI_WORD_A;
  localparam logic [31:0] PB  = sys_exc_pkg::ADDR_PRI_WORD_B;
  localparam logic [31:0] PC  = sys_exc_pkg::ADDR_PRI_WORD_C;
  localparam logic [31:0] HC  = sys_exc_pkg::ADDR_HANDLER_CTRL;
  localparam logic [31:0] KEY = 32'h05FA_0000;
  logic        sys_clk  = 1'b0;
  logic        tb_rst_n = 1'b0;
  logic [31:0] addr     = 32'h0000_0000;
  logic [31:0] wr_data  = 32'h0000_0000;
  logic        wr_en    = 1'b0;
  logic        rd_en    = 1'b0;
  logic [3:0]  pend_cmd = 4'h0;
  logic [3:0]  pend_clr = 4'h0;
  logic [6:0]  act_cmd  = 7'h00;
  logic [6:0]  act_clr  = 7'h00;
  logic        strap    = 1'b0;
  wire         rst_n;
  wire         warm_rst_n;
  wire  [3:0]  pend_set;
  wire  [6:0]  act_set;
  wire  [31:0] rd_data;
  wire         srr;
  wire         core_p;
  wire         clr_p;
  wire         big_endian;
  wire  [2:0]  grouping;
  wire  [2:0]  fault_en;
  wire  [3:0]  pending;
  wire  [6:0]  active;
  wire         irq;
  wire         preempt;
  wire  [3:0]  slot;
  int          n_mismatch = 0;
  int          cmp_count  = 0;
  int          cyc        = 0;

  always #5 sys_clk = ~sys_clk;
  assign rst_n = tb_rst_n & warm_rst_n;

  core_model core (.sys_clk, .pend_cmd, .act_cmd, .system_reset_request(srr), .pend_set,
    .act_set, .warm_rst_n);
  system_exception_control uut (.sys_clk, .rst_n, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
    .pend_set, .pend_clr, .act_set, .act_clr, .big_endian_strap(strap),
    .system_reset_request(srr), .core_reset_pulse(core_p), .clear_active_pulse(clr_p),
    .big_endian, .priority_grouping(grouping), .fault_enable(fault_en),
    .pending_flags(pending), .active_flags(active), .preempt_request(preempt),
    .preempt_slot(slot), .irq);

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string what);
    @(posedge sys_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1;
    check(what, exp, rd_data);
  endtask : rd

  // event pulse from the core, then two edges for flags to land
  task automatic ev(input logic [3:0] p, input logic [6:0] a);
    @(posedge sys_clk);
    pend_cmd <= p;
    act_cmd  <= a;
    @(posedge sys_clk);
    pend_cmd <= 4'h0;
    act_cmd  <= 7'h00;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask : ev

  task automatic t_reset;
    rd(RC, 32'hFA05_0000, "reset ctrl");
    rd(PA, 32'h0000_0000, "pri a");
    rd(PB, 32'h0000_0000, "pri b");
    rd(PC, 32'h0000_0000, "pri c");
    rd(HC, 32'h0000_0000, "handler");
    check("endian", 32'h0000_0000, {31'h0000_0000, big_endian});
    $display("test reset done");
  endtask : t_reset

  task automatic t_pri;
    wr(PA, 32'hFFFF_FFFF);
    wr(PB, 32'hFFFF_FFFF);
    wr(PC, 32'hFFFF_FFFF);
    rd(PA, 32'hE0E0_E0E0, "pri a all");
    rd(PB, 32'hE000_0000, "pri b all");
    rd(PC, 32'hE0E0_00E0, "pri c all");
    wr(PA, 32'h5F3F_BF7F);
    rd(PA, 32'h4020_A060, "pri a lanes");
    rd(32'hE000_ED30, 32'h0000_0000, "unmapped");
    $display("test priority done");
  endtask : t_pri

  task automatic t_key;
    wr(RC, 32'h0000_0503);
    check("core pulse", 32'h0000_0000, {31'h0000_0000, core_p});
    rd(RC, 32'hFA05_0000, "unkeyed");
    wr(RC, KEY | 32'h0000_0501);
    check("core pulse", 32'h0000_0001, {31'h0000_0000, core_p});
    rd(RC, 32'hFA05_0500, "keyed");
    $display("test key done");
  endtask : t_key

  task automatic t_clr;
    ev(4'h0, 7'h7F);
    rd(HC, 32'h0000_0D8B, "active bits");
    wr(RC, KEY);
    check("active", 32'h0000_007F, {25'h000_0000, active});
    wr(RC, KEY | 32'h0000_0002);
    check("clr pulse", 32'h0000_0001, {31'h0000_0000, clr_p});
    check("active", 32'h0000_0000, {25'h000_0000, active});
    rd(RC, 32'hFA05_0000, "clr self");
    $display("test clear active done");
  endtask : t_clr

  task automatic t_handler;
    wr(HC, 32'h0007_0000);
    check("enable", 32'h0000_0007, {29'h0000_0000, fault_en});
    ev(4'hF, 7'h00);
    rd(HC, 32'h0007_F000, "pending");
    check("preempt", 32'h0000_0001, {31'h0000_0000, preempt});
    check("slot", 32'h0000_0006, {28'h000_0000, slot});
    ev(4'h0, 7'h01);
    check("preempt mem act", 32'h0000_0001, {31'h0000_0000, preempt});
    wr(RC, KEY | 32'h0000_0600);
    @(posedge sys_clk);
    #1;
    check("preempt grouped", 32'h0000_0000, {31'h0000_0000, preempt});
    wr(RC, KEY);
    @(posedge sys_clk);
    pend_clr <= 4'hF;
    @(posedge sys_clk);
    pend_clr <= 4'h0;
    #1;
    check("pend clr", 32'h0000_0000, {28'h000_0000, pending});
    wr(HC, 32'h0000_0000);
    $display("test handler done");
  endtask : t_handler

  task automatic t_irq;
    wr(sys_exc_pkg::ADDR_EVENT_MASK, 32'h0000_0000);
    wr(sys_exc_pkg::ADDR_EVENT_STATUS, 32'h0000_00FF);
    ev(4'h2, 7'h00);
    rd(sys_exc_pkg::ADDR_EVENT_STATUS, 32'h0000_0002, "status");
    check("irq masked", 32'h0000_0000, {31'h0000_0000, irq});
    wr(sys_exc_pkg::ADDR_EVENT_MASK, 32'h0000_0002);
    @(posedge sys_clk);
    #1;
    check("irq", 32'h0000_0001, {31'h0000_0000, irq});
    wr(sys_exc_pkg::ADDR_EVENT_STATUS, 32'h0000_0002);
    @(posedge sys_clk);
    #1;
    check("irq clr", 32'h0000_0000, {31'h0000_0000, irq});
    $display("test irq done");
  endtask : t_irq

  // last: the request warm-resets the whole block
  task automatic t_srr;
    @(posedge sys_clk);
    strap <= 1'b1;
    wr(RC, KEY | 32'h0000_0304);
    check("sys req", 32'h0000_0001, {31'h0000_0000, srr});
    for (int i = 0; i < 8 && srr !== 1'b0; i++)
    begin
      @(posedge sys_clk);
      #1;
    end
    check("sys req", 32'h0000_0000, {31'h0000_0000, srr});
    repeat (2) @(posedge sys_clk);
    #1;
    check("endian strap", 32'h0000_0001, {31'h0000_0000, big_endian});
    rd(RC, 32'hFA05_8000, "after warm");
    $display("test system reset done");
  endtask : t_srr

  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      end_sim();
    end
  end

  initial
  begin
    repeat (3) @(posedge sys_clk);
    tb_rst_n <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_pri();
    t_key();
    t_clr();
    t_handler();
    t_irq();
    t_srr();
    end_sim();
  end
endmodule : system_exception_control_tb

bind system_exception_control sys_exc_chk chk (.sys_clk, .rst_n, .addr, .wr_data, .wr_en,
  .rd_en, .rd_data, .pend_set, .act_set, .system_reset_request, .core_reset_pulse,
  .clear_active_pulse, .priority_grouping, .fault_enable, .pending_flags, .active_flags);
